/* shared/sbtc_params.svh */
`ifndef SBTC_PARAMS_SVH
`define SBTC_PARAMS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SBTC_ADDR_CONTROL 4'h0
`define SBTC_ADDR_COUNT_LOW 4'h1
`define SBTC_ADDR_COUNT_HIGH 4'h2
`define SBTC_ADDR_STATUS 4'h3
`define SBTC_ADDR_IRQ_ENABLE 4'h4
`define SBTC_ADDR_SEV_CONTROL 4'h5
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SBTC_BIT_WIDE 7
`define SBTC_BIT_ASSIGN_HI 6
`define SBTC_BIT_PRESC_HI 5
`define SBTC_BIT_PRESC_LO 4
`define SBTC_BIT_ASSIGN_LO 3
`define SBTC_BIT_SYNC_DIS 2
`define SBTC_BIT_CLK_SRC 1
`define SBTC_BIT_RUN 0
`define SBTC_CONTROL_RESET 8'h00
// Other register fields
`define SBTC_BIT_OVF_FLAG 0
`define SBTC_BIT_OSC_EN 0
`define SBTC_BIT_SEV_UNIT_LO 0
`define SBTC_BIT_SEV_UNIT_HI 1
// ----------------------------------------
// Timing
// ----------------------------------------
`define SBTC_INSTR_DIV 4
`define SBTC_PRESC_MAX 8
`endif

/* shared/sbtc_pkg.sv */
package sbtc_pkg;
    // Operating mode decoded from control bits
    typedef enum logic [1:0] {
        SBTC_MODE_TIMER = 2'b00,
        SBTC_MODE_SYNC = 2'b01,
        SBTC_MODE_ASYNC = 2'b10
    } sbtc_mode_type;
    // Unit ownership, one bit per compare unit 1..5 (1 = this pair)
    typedef logic [4:0] sbtc_units_type;
endpackage

/* shared/sbtc_tick_if.sv */
`timescale 1ns/100ps
// Edge events from the clock front end to the counter core
interface sbtc_tick_if;
    logic tick;
    logic clear;
    modport source (output tick, input clear);
    modport sink (input tick, output clear);
endinterface

/* verilog/sbtc_edge_front.sv */
`timescale 1ns/100ps
`include "sbtc_params.svh"
// Picks internal or external count source and prescales it
module sbtc_edge_front import sbtc_pkg::*; #(
    parameter int PRESC_MAX = `SBTC_PRESC_MAX
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ext_level,
    input wire logic ext_raw,
    input wire logic clock_source_select,
    input wire logic ext_sync_disable,
    input wire logic count_run,
    input wire logic [1:0] prescale_sel,
    sbtc_tick_if.source tk
);
    // Prescale counter and mask are built for 1:8 at most
    if (PRESC_MAX != 8) begin : g_bad_presc
        $error("sbtc_edge_front: prescaler is fixed at 1:8");
    end
    logic [1:0] instr_div;
    logic ext_prev;
    logic fall_seen;
    logic [2:0] presc_cnt;
    // ----------------------------------------
    // Source selection
    // ----------------------------------------
    // Unsynchronised path still samples the raw pin once; a true async ripple needs a second clock
    wire ext_sel = ext_sync_disable ? ext_raw : ext_level;
    wire instr_tick = (instr_div == 2'h3);
    wire ext_rise = ext_sel & ~ext_prev & fall_seen;
    wire src_tick = clock_source_select ? ext_rise : instr_tick;
    wire [2:0] presc_mask = (prescale_sel == 2'h3) ? 3'h7 : (prescale_sel == 2'h2) ? 3'h3 :
                            (prescale_sel == 2'h1) ? 3'h1 : 3'h0;
    wire presc_done = ((presc_cnt & presc_mask) == presc_mask);
    // Instruction clock divider, free running
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end
    // External edge tracking, first falling edge arms counting
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_prev <= 1'b0;
            fall_seen <= 1'b0;
        end else begin
            ext_prev <= ext_sel;
            if (!clock_source_select) begin
                fall_seen <= 1'b0;
            end else if (ext_prev & ~ext_sel) begin
                fall_seen <= 1'b1;
            end
        end
    end
    // Prescaler; cleared by a low-byte write
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_cnt <= 3'h0;
            tk.tick <= 1'b0;
        end else begin
            tk.tick <= 1'b0;
            if (tk.clear) begin
                presc_cnt <= 3'h0;
            end else if (src_tick && count_run) begin
                presc_cnt <= presc_done ? 3'h0 : presc_cnt + 3'h1;
                tk.tick <= presc_done;
            end
        end
    end
endmodule // sbtc_edge_front

/* verilog/sbtc_pin_sync.sv */
`timescale 1ns/100ps
// Two flip-flop level synchroniser, one per bit
module sbtc_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // A zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("sbtc_pin_sync: WIDTH must be at least 1");
    end
    logic [WIDTH-1:0] meta;
    // First stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta[g] <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    meta[g] <= async_in[g];
                    sync_out[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule // sbtc_pin_sync

/* verilog/sbtc_timer.sv */
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "sbtc_params.svh"
// Summary of operation
// - Wide-access bit selects 16-bit or byte access
// - Two assign bits route timer pair to units
// - Prescale field divides by 1, 2, 4, 8
// - External source synchronised unless sync-disable set
// - Internal source ignores the sync-disable bit
// - Count external rising edges after first falling
// - Internal source counts every fourth system clock
// - Count advances only while run bit set
// - Timer, synchronous and asynchronous counter modes
// - Oscillator enabled: pins forced input, read zero
// - Wide mode: low read latches high buffer
// - Wide mode: low write loads both bytes
// - Wide mode: high byte only through buffer
// - Low-byte write clears prescaler, high does not
// - Wrap FFFF to 0000 sets overflow flag
// - Special event resets count outside async mode, no flag
// - Software write beats same-cycle special event
module sbtc_timer import sbtc_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic external_count_pin,
    input wire logic osc_input_pin,
    input wire logic [1:0] port_pin_in,
    input wire logic [1:0] port_direction_reg,
    output logic [1:0] port_pin_read,
    output logic [1:0] port_pin_oe,
    // Compare unit special-event triggers, units 1..5
    input wire logic [4:0] unit_event,
    // Status outputs
    output logic overflow_irq,
    output logic [4:0] unit_uses_pair,
    output logic [1:0] op_mode
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] timer_control;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic osc_enable;
    logic [1:0] sev_units;
    logic [1:0] pins_sync;
    sbtc_tick_if tk ();

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    wire wide_access_enable = timer_control[`SBTC_BIT_WIDE];
    wire unit_assign_hi = timer_control[`SBTC_BIT_ASSIGN_HI];
    wire unit_assign_lo = timer_control[`SBTC_BIT_ASSIGN_LO];
    wire prescale_sel_hi = timer_control[`SBTC_BIT_PRESC_HI];
    wire prescale_sel_lo = timer_control[`SBTC_BIT_PRESC_LO];
    wire ext_sync_disable = timer_control[`SBTC_BIT_SYNC_DIS];
    wire clock_source_select = timer_control[`SBTC_BIT_CLK_SRC];
    wire count_run = timer_control[`SBTC_BIT_RUN];
    wire [1:0] assign_field = {unit_assign_hi, unit_assign_lo};

    // Unit map: bit n-1 set when unit n uses this pair
    wire [4:0] next_units = (assign_field == 2'h3) ? 5'h1F :
                            (assign_field == 2'h2) ? 5'h1C :
                            (assign_field == 2'h1) ? 5'h1E : 5'h00;
    wire sbtc_mode_type next_mode = !clock_source_select ? SBTC_MODE_TIMER :
                                    ext_sync_disable ? SBTC_MODE_ASYNC : SBTC_MODE_SYNC;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire wr_control = reg_write && (reg_addr == `SBTC_ADDR_CONTROL);
    wire wr_low = reg_write && (reg_addr == `SBTC_ADDR_COUNT_LOW);
    wire wr_high = reg_write && (reg_addr == `SBTC_ADDR_COUNT_HIGH);
    wire wr_status = reg_write && (reg_addr == `SBTC_ADDR_STATUS);
    wire wr_irq_en = reg_write && (reg_addr == `SBTC_ADDR_IRQ_ENABLE);
    wire wr_sev = reg_write && (reg_addr == `SBTC_ADDR_SEV_CONTROL);
    wire rd_low = reg_read && (reg_addr == `SBTC_ADDR_COUNT_LOW);

    // ----------------------------------------
    // Count source
    // ----------------------------------------
    // Both clock pins synchronised before the source mux; the sync-disable path below also samples them raw
    logic [1:0] clk_pins_sync;
    sbtc_pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in({port_pin_in, osc_input_pin, external_count_pin}),
        .sync_out({pins_sync, clk_pins_sync})
    );
    // Oscillator pin or count pin; either may drive the external clock
    wire ext_level = osc_enable ? clk_pins_sync[1] : clk_pins_sync[0];

    // Unsynchronised path is sampled by one flop only; caller in mind
    logic [1:0] clk_pins_raw_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_pins_raw_q <= 2'h0;
        end else begin
            clk_pins_raw_q <= {osc_input_pin, external_count_pin};
        end
    end
    wire ext_raw_q = osc_enable ? clk_pins_raw_q[1] : clk_pins_raw_q[0];

    sbtc_edge_front #(
        .PRESC_MAX(`SBTC_PRESC_MAX)
    ) u_front (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ext_level(ext_level),
        .ext_raw(ext_raw_q),
        .clock_source_select(clock_source_select),
        .ext_sync_disable(ext_sync_disable),
        .count_run(count_run),
        .prescale_sel({prescale_sel_hi, prescale_sel_lo}),
        .tk(tk)
    );
    assign tk.clear = wr_low;

    // ----------------------------------------
    // Special event
    // ----------------------------------------
    // Only units selected for reset and owned by this pair act; async mode ignores it
    wire [4:0] sev_mask = {3'h0, sev_units} & next_units;
    wire sev_hit = |(unit_event & sev_mask) && (next_mode != SBTC_MODE_ASYNC);
    wire wrap = tk.tick && (count == 16'hFFFF);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Software writes first, then special event, then the tick
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 16'h0000;
        end else if (wr_low) begin
            count[7:0] <= reg_wdata;
            if (wide_access_enable) begin
                count[15:8] <= high_buffer;
            end
        end else if (wr_high && !wide_access_enable) begin
            count[15:8] <= reg_wdata;
        end else if (sev_hit) begin
            count <= 16'h0000;
        end else if (tk.tick) begin
            count <= count + 16'h0001;
        end
    end

    // High byte buffer: written in wide mode, latched on low read
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_buffer <= 8'h00;
        end else if (wide_access_enable && wr_high) begin
            high_buffer <= reg_wdata;
        end else if (wide_access_enable && rd_low) begin
            high_buffer <= count[15:8];
        end
    end

    // ----------------------------------------
    // Control and status registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_control <= `SBTC_CONTROL_RESET;
            overflow_irq_enable <= 1'b0;
            osc_enable <= 1'b0;
            sev_units <= 2'h0;
        end else begin
            if (wr_control) begin
                timer_control <= reg_wdata;
            end
            if (wr_irq_en) begin
                overflow_irq_enable <= reg_wdata[0];
                osc_enable <= reg_wdata[1];
            end
            if (wr_sev) begin
                sev_units <= reg_wdata[1:0];
            end
        end
    end

    // Overflow flag: set wins over a software clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (wr_status && !reg_wdata[`SBTC_BIT_OVF_FLAG]) begin
            overflow_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Wide mode: high address returns the buffer, never the live byte
    wire [7:0] high_view = wide_access_enable ? high_buffer : count[15:8];
    wire [7:0] next_rdata = (reg_addr == `SBTC_ADDR_CONTROL) ? timer_control :
                            (reg_addr == `SBTC_ADDR_COUNT_LOW) ? count[7:0] :
                            (reg_addr == `SBTC_ADDR_COUNT_HIGH) ? high_view :
                            (reg_addr == `SBTC_ADDR_STATUS) ? {7'h00, overflow_flag} :
                            (reg_addr == `SBTC_ADDR_IRQ_ENABLE) ? {6'h00, osc_enable, overflow_irq_enable} :
                            (reg_addr == `SBTC_ADDR_SEV_CONTROL) ? {6'h00, sev_units} : 8'h00;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? next_rdata : 8'h00;
        end
    end

    // ----------------------------------------
    // Pins and status outputs
    // ----------------------------------------
    // Oscillator pins forced to inputs reading zero; direction reg 0 means drive
    wire [1:0] next_oe = osc_enable ? 2'h0 : ~port_direction_reg;
    wire [1:0] next_pin_read = osc_enable ? 2'h0 : pins_sync;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_pin_oe <= 2'h0;
            port_pin_read <= 2'h0;
            overflow_irq <= 1'b0;
            unit_uses_pair <= 5'h00;
            op_mode <= 2'h0;
        end else begin
            port_pin_oe <= next_oe;
            port_pin_read <= next_pin_read;
            overflow_irq <= (overflow_flag | wrap) & overflow_irq_enable;
            unit_uses_pair <= next_units;
            op_mode <= next_mode;
        end
    end
endmodule // sbtc_timer

/* sim/sbtc_timer_properties.sv */
`timescale 1ns/100ps
`include "sbtc_params.svh"
// ----------------------------------------
// Port checker for the timer
// ----------------------------------------
module sbtc_timer_checker import sbtc_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic external_count_pin,
    input wire logic osc_input_pin,
    input wire logic [1:0] port_pin_in,
    input wire logic [1:0] port_direction_reg,
    input wire logic [1:0] port_pin_read,
    input wire logic [1:0] port_pin_oe,
    input wire logic [4:0] unit_event,
    input wire logic overflow_irq,
    input wire logic [4:0] unit_uses_pair,
    input wire logic [1:0] op_mode
);
    logic [7:0] ctl_w;
    logic [1:0] en_w;
    // Shadow of what software wrote
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_w <= 8'h00;
            en_w <= 2'h0;
        end else if (reg_write && reg_addr == `SBTC_ADDR_CONTROL) begin
            ctl_w <= reg_wdata;
        end else if (reg_write && reg_addr == `SBTC_ADDR_IRQ_ENABLE) begin
            en_w <= reg_wdata[1:0];
        end
    end
    // Expected decodes of the shadow
    wire [1:0] asg = {ctl_w[6], ctl_w[3]};
    wire [4:0] exp_units = asg == 2'h3 ? 5'h1F : asg == 2'h2 ? 5'h1C : asg == 2'h1 ? 5'h1E : 5'h00;
    wire [1:0] exp_mode = !ctl_w[1] ? 2'h0 : ctl_w[2] ? 2'h2 : 2'h1;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Registered outputs need a few write-free cycles to settle
    sequence quiet;
        !reg_write [*3];
    endsequence
    chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    chk_unmapped_zero: assert property (reg_read && reg_addr > `SBTC_ADDR_SEV_CONTROL |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (reg_read && reg_addr == `SBTC_ADDR_CONTROL |=> reg_rdata == $past(ctl_w))
        else $error("control read back wrong");
    chk_enable_readback: assert property (reg_read && reg_addr == `SBTC_ADDR_IRQ_ENABLE
        |=> reg_rdata[1:0] == $past(en_w))
        else $error("enable read back wrong");
    chk_unit_map: assert property (quiet |-> unit_uses_pair == exp_units)
        else $error("unit map wrong");
    chk_mode_map: assert property (quiet |-> op_mode == exp_mode)
        else $error("mode wrong");
    chk_pin_oe: assert property ((!reg_write && $stable(port_direction_reg)) [*3]
        |-> port_pin_oe == (en_w[1] ? 2'h0 : ~port_direction_reg))
        else $error("pin enable wrong");
    chk_osc_pins_zero: assert property (quiet ##0 en_w[1] |-> port_pin_read == 2'h0)
        else $error("pins not zero under oscillator");
    chk_irq_gate: assert property (quiet ##0 !en_w[0] |-> !overflow_irq)
        else $error("interrupt while disabled");
endmodule // sbtc_timer_checker

bind sbtc_timer sbtc_timer_checker u_chk (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .external_count_pin, .osc_input_pin, .port_pin_in, .port_direction_reg, .port_pin_read,
    .port_pin_oe, .unit_event, .overflow_irq, .unit_uses_pair, .op_mode);

/* sim/sbtc_count_source.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Far-side count clock
// ----------------------------------------
module sbtc_count_source (
    input wire logic ref_clk,
    output logic count_clk
);
    // Parked low, so the block must see a fall first; never feeds the system clock
    initial begin
        count_clk = 1'b0;
    end
    // Burst of n rising edges, each level held half cycles
    task automatic send(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge ref_clk);
            count_clk <= 1'b1;
            repeat (half) @(posedge ref_clk);
            count_clk <= 1'b0;
        end
    endtask
endmodule // sbtc_count_source

/* sim/testbench.sv */
`timescale 1ns/100ps
`include "sbtc_params.svh"
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module testbench import sbtc_pkg::*; ;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [1:0] port_pin_in = 2'h0;
    logic [1:0] port_direction_reg = 2'h3;
    logic [4:0] unit_event = 5'h00;
    logic [7:0] reg_rdata, lo, hi;
    logic [1:0] port_pin_read, port_pin_oe, op_mode;
    logic overflow_irq, count_clk, rd_seen;
    logic [4:0] unit_uses_pair;
    logic [9:0] note;
    logic [9:0] exp_q[$];
    logic [7:0] last_rd = 8'h00;
    logic [4:0] umap[4] = '{5'h00, 5'h1E, 5'h1C, 5'h1F};
    int errors = 0;
    int check_count = 0;
    int seed = 32'h827B34B8;
    initial begin
        forever begin
            #2.5 ref_clk = ~ref_clk;
        end
    end
    sbtc_timer u_sbtc_timer (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .external_count_pin(count_clk),
        .osc_input_pin(count_clk), .port_pin_in(port_pin_in), .port_direction_reg(port_direction_reg),
        .port_pin_read(port_pin_read), .port_pin_oe(port_pin_oe), .unit_event(unit_event),
        .overflow_irq(overflow_irq), .unit_uses_pair(unit_uses_pair), .op_mode(op_mode));
    sbtc_count_source u_sbtc_count_source (.ref_clk(ref_clk), .count_clk(count_clk));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Strobe tasks set both strobes, so no signal is assigned twice per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Kind 0 exact, 1 change since last read, 2 only recorded
    task automatic rd(input logic [3:0] a, input logic [1:0] k, input logic [7:0] e);
        exp_q.push_back({k, e});
        reg_addr <= a;
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic idle(input int n);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic complete_run();
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Read answers checked mid-cycle against the oldest note
    always @(posedge ref_clk) begin
        rd_seen <= reg_read;
    end
    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            note = exp_q.pop_front();
            if (note[9:8] != 2'h2) begin
                chk("reg_rdata", note[7:0], note[8] ? reg_rdata - last_rd : reg_rdata);
            end
            last_rd = reg_rdata;
        end
    end
    // Hang guard, well beyond the under one thousand cycles of the run
    initial begin
        #50000;
        errors++;
        complete_run();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(`SBTC_ADDR_CONTROL, 2'h0, 8'h00);
        wr(4'hF, 8'hA5);
        rd(4'hF, 2'h0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`SBTC_ADDR_CONTROL, {1'b0, i[1], 2'h0, i[0], 3'h0});
            idle(3);
            chk("unit_uses_pair", {3'h0, umap[i]}, {3'h0, unit_uses_pair});
        end
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        wr(`SBTC_ADDR_COUNT_LOW, lo);
        wr(`SBTC_ADDR_COUNT_HIGH, hi);
        rd(`SBTC_ADDR_COUNT_LOW, 2'h0, lo);
        rd(`SBTC_ADDR_COUNT_HIGH, 2'h0, hi);
        // Five prescaled ticks per window; sync bit toggled, internal ignores it
        for (int p = 0; p < 4; p++) begin
            wr(`SBTC_ADDR_CONTROL, {2'h0, p[1:0], 1'b0, p[0], 2'h1});
            // Old run and prescale bits still rule the write edge; start the window after it
            idle(1);
            rd(`SBTC_ADDR_COUNT_LOW, 2'h2, 8'h00);
            idle(20 * (1 << p) - 1);
            rd(`SBTC_ADDR_COUNT_LOW, 2'h1, 8'h05);
            chk("op_mode", 8'h00, {6'h0, op_mode});
        end
        wr(`SBTC_ADDR_CONTROL, 8'h30);
        idle(1);
        rd(`SBTC_ADDR_COUNT_LOW, 2'h2, 8'h00);
        idle(39);
        rd(`SBTC_ADDR_COUNT_LOW, 2'h1, 8'h00);
        wr(`SBTC_ADDR_CONTROL, 8'h31);
        repeat (6) begin
            wr(`SBTC_ADDR_COUNT_LOW, 8'h00);
            idle(15);
        end
        rd(`SBTC_ADDR_COUNT_LOW, 2'h0, 8'h00);
        idle(15);
        repeat (5) begin
            wr(`SBTC_ADDR_COUNT_HIGH, 8'h00);
            idle(15);
        end
        rd(`SBTC_ADDR_COUNT_LOW, 2'h1, 8'h03);
        wr(`SBTC_ADDR_CONTROL, 8'h80);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h56);
        rd(`SBTC_ADDR_COUNT_HIGH, 2'h0, 8'h56);
        wr(`SBTC_ADDR_COUNT_LOW, 8'h78);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h9A);
        wr(`SBTC_ADDR_CONTROL, 8'h00);
        rd(`SBTC_ADDR_COUNT_HIGH, 2'h0, 8'h56);
        rd(`SBTC_ADDR_COUNT_LOW, 2'h0, 8'h78);
        wr(`SBTC_ADDR_CONTROL, 8'h80);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h11);
        rd(`SBTC_ADDR_COUNT_LOW, 2'h0, 8'h78);
        rd(`SBTC_ADDR_COUNT_HIGH, 2'h0, 8'h56);
        wr(`SBTC_ADDR_CONTROL, 8'h00);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'hFF);
        wr(`SBTC_ADDR_COUNT_LOW, 8'hFE);
        wr(`SBTC_ADDR_IRQ_ENABLE, 8'h01);
        wr(`SBTC_ADDR_CONTROL, 8'h01);
        idle(1);
        for (int n = 0; n < 40 && overflow_irq !== 1'b1; n++) @(negedge ref_clk);
        @(posedge ref_clk);
        chk("overflow_irq", 8'h01, {7'h0, overflow_irq});
        wr(`SBTC_ADDR_CONTROL, 8'h00);
        rd(`SBTC_ADDR_COUNT_HIGH, 2'h0, 8'h00);
        rd(`SBTC_ADDR_STATUS, 2'h0, 8'h01);
        wr(`SBTC_ADDR_STATUS, 8'h00);
        idle(3);
        chk("overflow_irq", 8'h00, {7'h0, overflow_irq});
        wr(`SBTC_ADDR_CONTROL, 8'h49);
        wr(`SBTC_ADDR_SEV_CONTROL, 8'h01);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h40);
        unit_event <= 5'h01;
        idle(1);
        unit_event <= 5'h00;
        wr(`SBTC_ADDR_CONTROL, 8'h48);
        rd(`SBTC_ADDR_COUNT_HIGH, 2'h0, 8'h00);
        rd(`SBTC_ADDR_STATUS, 2'h0, 8'h00);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h40);
        unit_event <= 5'h01;
        wr(`SBTC_ADDR_COUNT_LOW, 8'h55);
        unit_event <= 5'h00;
        rd(`SBTC_ADDR_COUNT_HIGH, 2'h0, 8'h40);
        rd(`SBTC_ADDR_COUNT_LOW, 2'h0, 8'h55);
        // Pin parked low: first rise is not counted, so four rises give three
        for (int k = 0; k < 2; k++) begin
            wr(`SBTC_ADDR_COUNT_LOW, 8'h00);
            wr(`SBTC_ADDR_CONTROL, k ? 8'h07 : 8'h03);
            idle(3);
            chk("op_mode", k ? 8'h02 : 8'h01, {6'h0, op_mode});
            u_sbtc_count_source.send(4, 6);
            idle(8);
            rd(`SBTC_ADDR_COUNT_LOW, 2'h0, 8'h03);
            wr(`SBTC_ADDR_CONTROL, 8'h00);
        end
        port_pin_in <= 2'($random(seed)) | 2'h1; // Never all zero, so the forced zero can trip
        port_direction_reg <= 2'h1;
        idle(4);
        chk("port_pin_oe", 8'h02, {6'h0, port_pin_oe});
        chk("port_pin_read", {6'h0, port_pin_in}, {6'h0, port_pin_read});
        wr(`SBTC_ADDR_IRQ_ENABLE, 8'h03);
        idle(4);
        chk("port_pin_oe", 8'h00, {6'h0, port_pin_oe});
        chk("port_pin_read", 8'h00, {6'h0, port_pin_read});
        idle(2);
        complete_run();
    end
endmodule // testbench
